/* design/lsmg_defs.vh */
`ifndef LSMG_DEFS_VH
`define LSMG_DEFS_VH

// ----------------------------------------
// Register indices and address slice bounds
// ----------------------------------------
`define LSMG_IDX_STATUS 8'h13
`define LSMG_IDX_RXGAIN 8'h14
`define LSMG_IDX_TXGAIN 8'h15
`define LSMG_IDX_STICKY 8'h40
`define LSMG_IDX_IRQST 8'h41
`define LSMG_IDX_IRQMSK 8'h42
`define LSMG_IDX_CTRL 8'h43
`define LSMG_ADDR_W 10
`define LSMG_ADDR_LSB 2
`define LSMG_NUM_FLAGS 3

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LSMG_BIT_OPD 0
`define LSMG_BIT_DOD 1
`define LSMG_BIT_OVL 2
`define LSMG_BIT_STICKY 0
`define LSMG_BIT_CURRENT_LIMIT_SELECT 0
`define LSMG_BIT_BTE 1
`define LSMG_RST_BYTE 8'h00
`define LSMG_RST_FLAGS 3'b000
`define LSMG_RST_CTRL 2'b00
`define LSMG_RST_WORD 32'h0000_0000
`define LSMG_ZERO5 5'h00
`define LSMG_ZERO6 6'h00
`define LSMG_ZERO7 7'h00
`define LSMG_RST_SAMPLE 16'h0000
`define LSMG_ZERO24 24'h00_0000

// ----------------------------------------
// Overcurrent thresholds in mA
// ----------------------------------------
`define LSMG_TRIP_HIGH_MA 8'hA0
`define LSMG_TRIP_LOW_MA 8'h3C

// ----------------------------------------
// Gain scaling and sample limits
// ----------------------------------------
`define LSMG_GAIN_SHIFT 6
`define LSMG_SAMPLE_MAX 16'h7FFF
`define LSMG_SAMPLE_MIN 16'h8000
`define LSMG_SUM_MAX 20'sh0_7FFF
`define LSMG_SUM_MIN -20'sh0_8000

// ----------------------------------------
// AHB-Lite codes
// ----------------------------------------
`define LSMG_HTRANS_NONSEQ 2'b10
`define LSMG_HTRANS_SEQ 2'b11
`define LSMG_HRESP_OKAY 1'b0

`endif

/* design/lsmg_line_status.v */
`timescale 1ns/1ps
`include "lsmg_defs.vh"

module lsmg_line_status (
  input wire clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire rxInputExcessive,
  input wire offHookSettling,
  input wire linePowerCollapsed,
  input wire onHook,
  input wire lineSideEnabled,
  input wire [7:0] loopCurrentMa,
  input wire signed [15:0] rxSample,
  input wire signed [15:0] txSample,
  output reg signed [15:0] monitorOutput,
  output reg currentLimitSelect,
  output reg billingToneEnable,
  output reg irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0] liveFlags;
  reg [2:0] prevFlags;
  reg [2:0] irqStatus;
  reg [2:0] irqMask;
  reg stickyOverloadFlag;
  reg [7:0] monitorRxGainCode;
  reg [7:0] monitorTxGainCode;
  reg wrPending;
  reg [7:0] wrIndex;
  reg [31:0] next_hrdata;
  reg signed [15:0] next_monitorOutput;

  // ----------------------------------------
  // Address phase decode
  // ----------------------------------------
  // Every register is one aligned word, so the transfer size is not looked at.
  wire activeTransfer;
  wire accept;
  wire readAccept;
  wire writeAccept;
  wire [7:0] addrIndex;
  wire [7:0] wrByte;
  wire wrRxGain;
  wire wrTxGain;
  wire wrIrqMask;
  wire wrCtrl;
  wire wrIrqSt;
  wire wrSticky;

  assign activeTransfer = (htrans == `LSMG_HTRANS_NONSEQ) | (htrans == `LSMG_HTRANS_SEQ);
  assign accept = hsel & hready & activeTransfer;
  assign readAccept = accept & ~hwrite;
  assign writeAccept = accept & hwrite;
  assign addrIndex = haddr[`LSMG_ADDR_W-1:`LSMG_ADDR_LSB];
  assign wrByte = hwdata[7:0];

  // ----------------------------------------
  // Data phase write strobes
  // ----------------------------------------
  // The status index has no strobe, so writes to it fall away.
  assign wrRxGain = wrPending & (wrIndex == `LSMG_IDX_RXGAIN);
  assign wrTxGain = wrPending & (wrIndex == `LSMG_IDX_TXGAIN);
  assign wrIrqMask = wrPending & (wrIndex == `LSMG_IDX_IRQMSK);
  assign wrCtrl = wrPending & (wrIndex == `LSMG_IDX_CTRL);
  assign wrIrqSt = wrPending & (wrIndex == `LSMG_IDX_IRQST);
  assign wrSticky = wrPending & (wrIndex == `LSMG_IDX_STICKY);

  // ----------------------------------------
  // Line condition detection
  // ----------------------------------------
  wire overloadNow;
  wire dropoutNow;
  wire [7:0] tripLevel;
  wire overcurrentNow;
  wire [2:0] next_liveFlags;
  wire [2:0] riseEvents;
  wire [2:0] irqClear;
  wire [2:0] next_irqStatus;

  // The billing tone setting is kept out of this term on purpose.
  assign overloadNow = rxInputExcessive & ~offHookSettling;
  assign dropoutNow = linePowerCollapsed | (onHook & lineSideEnabled);
  assign tripLevel = currentLimitSelect ? `LSMG_TRIP_LOW_MA : `LSMG_TRIP_HIGH_MA;
  assign overcurrentNow = loopCurrentMa >= tripLevel;
  assign next_liveFlags[`LSMG_BIT_OVL] = overloadNow;
  assign next_liveFlags[`LSMG_BIT_DOD] = dropoutNow;
  assign next_liveFlags[`LSMG_BIT_OPD] = overcurrentNow;
  assign irqClear = wrIrqSt ? hwdata[`LSMG_NUM_FLAGS-1:0] : `LSMG_RST_FLAGS;

  // Registering the flags costs a cycle but keeps the readback free of input glitches.
  always @(posedge clk) begin
    if (sys_rst) begin
      liveFlags <= `LSMG_RST_FLAGS;
      prevFlags <= `LSMG_RST_FLAGS;
    end else begin
      liveFlags <= next_liveFlags;
      prevFlags <= liveFlags;
    end
  end

  // ----------------------------------------
  // Per-flag interrupt events
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LSMG_NUM_FLAGS; g = g + 1) begin : gen_flag
      assign riseEvents[g] = liveFlags[g] & ~prevFlags[g];
      // A new event in the clearing cycle survives the write-one clear.
      assign next_irqStatus[g] = (irqStatus[g] & ~irqClear[g]) | riseEvents[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      irqStatus <= `LSMG_RST_FLAGS;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      // The pin comes from a flip-flop, one cycle behind the status bits.
      irq <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------
  // Sticky overload flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      stickyOverloadFlag <= 1'b0;
    end else if (overloadNow) begin
      // Set wins over a clear that lands in the same cycle.
      stickyOverloadFlag <= 1'b1;
    end else if (wrSticky & ~wrByte[`LSMG_BIT_STICKY]) begin
      stickyOverloadFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register bus slave: write path
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      wrPending <= 1'b0;
      wrIndex <= `LSMG_RST_BYTE;
    end else begin
      wrPending <= writeAccept;
      wrIndex <= addrIndex;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      monitorRxGainCode <= `LSMG_RST_BYTE;
    end else if (wrRxGain) begin
      monitorRxGainCode <= wrByte;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      monitorTxGainCode <= `LSMG_RST_BYTE;
    end else if (wrTxGain) begin
      monitorTxGainCode <= wrByte;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irqMask <= `LSMG_RST_FLAGS;
    end else if (wrIrqMask) begin
      irqMask <= wrByte[`LSMG_NUM_FLAGS-1:0];
    end
  end

  // The billing tone bit drives nothing inside this block but the CTRL readback; otherwise it only leaves on a pin.
  always @(posedge clk) begin
    if (sys_rst) begin
      currentLimitSelect <= 1'b0;
      billingToneEnable <= 1'b0;
    end else if (wrCtrl) begin
      currentLimitSelect <= wrByte[`LSMG_BIT_CURRENT_LIMIT_SELECT];
      billingToneEnable <= wrByte[`LSMG_BIT_BTE];
    end
  end

  // ----------------------------------------
  // Register bus slave: read path
  // ----------------------------------------
  always @* begin
    next_hrdata = `LSMG_RST_WORD;
    case (addrIndex)
      `LSMG_IDX_STATUS: begin
        next_hrdata = {`LSMG_ZERO24, `LSMG_ZERO5, liveFlags};
      end
      `LSMG_IDX_RXGAIN: begin
        next_hrdata = {`LSMG_ZERO24, monitorRxGainCode};
      end
      `LSMG_IDX_TXGAIN: begin
        next_hrdata = {`LSMG_ZERO24, monitorTxGainCode};
      end
      `LSMG_IDX_STICKY: begin
        next_hrdata = {`LSMG_ZERO24, `LSMG_ZERO7, stickyOverloadFlag};
      end
      `LSMG_IDX_IRQST: begin
        next_hrdata = {`LSMG_ZERO24, `LSMG_ZERO5, irqStatus};
      end
      `LSMG_IDX_IRQMSK: begin
        next_hrdata = {`LSMG_ZERO24, `LSMG_ZERO5, irqMask};
      end
      `LSMG_IDX_CTRL: begin
        next_hrdata = {`LSMG_ZERO24, `LSMG_ZERO6, billingToneEnable, currentLimitSelect};
      end
      default: begin
        next_hrdata = `LSMG_RST_WORD;
      end
    endcase
  end

  // Zero wait states: every transfer ends in its first data cycle, always OKAY.
  always @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= `LSMG_HRESP_OKAY;
      hrdata <= `LSMG_RST_WORD;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `LSMG_HRESP_OKAY;
      if (readAccept) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // ----------------------------------------
  // Monitor mix
  // ----------------------------------------
  // Full products are kept so that the top codes reach about +12 dB without wrap.
  wire signed [8:0] rxGainSigned;
  wire signed [8:0] txGainSigned;
  wire signed [24:0] rxScaled;
  wire signed [24:0] txScaled;
  wire signed [25:0] mixSum;
  wire signed [19:0] mixShifted;

  assign rxGainSigned = {1'b0, monitorRxGainCode};
  assign txGainSigned = {1'b0, monitorTxGainCode};
  assign rxScaled = rxSample * rxGainSigned;
  assign txScaled = txSample * txGainSigned;
  assign mixSum = rxScaled + txScaled;
  assign mixShifted = mixSum[25:`LSMG_GAIN_SHIFT];

  // Loud lines with high codes clip rather than wrap around.
  always @* begin
    next_monitorOutput = `LSMG_RST_SAMPLE;
    if (mixShifted > `LSMG_SUM_MAX) begin
      next_monitorOutput = `LSMG_SAMPLE_MAX;
    end else if (mixShifted < `LSMG_SUM_MIN) begin
      next_monitorOutput = `LSMG_SAMPLE_MIN;
    end else begin
      next_monitorOutput = mixShifted[15:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      monitorOutput <= `LSMG_RST_SAMPLE;
    end else begin
      monitorOutput <= next_monitorOutput;
    end
  end

endmodule

/* test/lsmg_line_status_sva.sv */
`timescale 1ns/1ps
`include "lsmg_defs.vh"
module lsmg_line_status_sva (
  input wire clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire rxInputExcessive,
  input wire offHookSettling,
  input wire linePowerCollapsed,
  input wire onHook,
  input wire lineSideEnabled,
  input wire [7:0] loopCurrentMa,
  input wire signed [15:0] rxSample,
  input wire signed [15:0] txSample,
  input wire signed [15:0] monitorOutput,
  input wire currentLimitSelect,
  input wire billingToneEnable,
  input wire irq
);
  // ----------------------------------------
  // Status reads lag the inputs by two edges.
  // ----------------------------------------
  wire acc = hsel && hready && htrans[1];
  wire rdSt = acc && !hwrite && haddr == {22'h00_0000, `LSMG_IDX_STATUS, 2'b00};
  wire wrCtl = acc && hwrite && haddr == {22'h00_0000, `LSMG_IDX_CTRL, 2'b00};
  wire [2:0] stNow = {rxInputExcessive && !offHookSettling,
    linePowerCollapsed || onHook && lineSideEnabled,
    loopCurrentMa >= (currentLimitSelect ? 8'h3C : 8'hA0)};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer wrong");
  property p_ovl; rdSt |=> hrdata[2] == $past(stNow[2], 2); endproperty
  a_ovl: assert property (p_ovl) else $error("overload bit wrong");
  property p_dod; rdSt |=> hrdata[1] == $past(stNow[1], 2); endproperty
  a_dod: assert property (p_dod) else $error("dropout bit wrong");
  property p_opd; rdSt |=> hrdata[0] == $past(stNow[0], 2); endproperty
  a_opd: assert property (p_opd) else $error("overcurrent bit wrong");
  property p_upper; rdSt |=> hrdata[31:3] == 29'h0000_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_hold; !(acc && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_mute; rxSample == 16'h0000 && txSample == 16'h0000 |=> monitorOutput == 16'h0000;
  endproperty
  a_mute: assert property (p_mute) else $error("monitor not silent");
  property p_ctl; wrCtl ##1 1'b1 |=> currentLimitSelect == $past(hwdata[0])
    && billingToneEnable == $past(hwdata[1]); endproperty
  a_ctl: assert property (p_ctl) else $error("control bits wrong");
  c_rd: cover property (rdSt ##1 hrdata[2]);
  c_irq: cover property ($rose(irq));
  c_mon: cover property (monitorOutput != 16'h0000);
endmodule
bind lsmg_line_status lsmg_line_status_sva i_lsmg_line_status_sva (.*);

/* test/lsmg_line_status_test.sv */
`timescale 1ns/1ps
`include "lsmg_defs.vh"
module lsmg_line_status_test;
  reg clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, r;
  reg [1:0] htrans = 2'b00;
  reg rxInputExcessive = 1'b0, offHookSettling = 1'b0, linePowerCollapsed = 1'b0;
  reg onHook = 1'b0, lineSideEnabled = 1'b0;
  reg [7:0] loopCurrentMa = 8'h00;
  reg signed [15:0] rxSample = 16'h0000, txSample = 16'h0000;
  wire hreadyout, hresp, currentLimitSelect, billingToneEnable, irq;
  wire [31:0] hrdata;
  wire signed [15:0] monitorOutput;
  wire hready = hreadyout;
  wire [2:0] hsize = 3'b010;
  integer bad_count = 0, checks_done = 0, cycles = 0;
  lsmg_line_status i_lsmg_line_status (.*);
  always #25 clk = ~clk;
  // ----------------------------------------
  // A hung handshake is cut short here.
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish; begin
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end endtask
  task cmp(input [31:0] g, input [31:0] e); begin
    checks_done = checks_done + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  end endtask
  task bus(input w, input [7:0] i, input [31:0] d); begin
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `LSMG_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h00_0000, i, 2'b00};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  end endtask
  task rd(input [7:0] i, input [31:0] e); begin
    bus(1'b0, i, 32'h0000_0000);
    cmp(r, e);
  end endtask
  task st(input [4:0] v, input [7:0] c, input [2:0] e); begin
    {rxInputExcessive, offHookSettling, linePowerCollapsed, onHook, lineSideEnabled} <= v;
    loopCurrentMa <= c;
    repeat (3) @(posedge clk);
    rd(`LSMG_IDX_STATUS, {29'h0000_0000, e});
  end endtask
  task t_status; begin
    rd(8'h7F, 32'h0000_0000);
    st(5'b10000, 8'h00, 3'b100);
    st(5'b11000, 8'h00, 3'b000);
    bus(1'b1, `LSMG_IDX_CTRL, 32'h0000_0002);
    st(5'b10000, 8'h00, 3'b100);
    st(5'b00100, 8'h00, 3'b010);
    st(5'b00011, 8'h9F, 3'b010);
    st(5'b00010, 8'hA0, 3'b001);
    bus(1'b1, `LSMG_IDX_CTRL, 32'h0000_0001);
    st(5'b00000, 8'h3C, 3'b001);
    bus(1'b1, `LSMG_IDX_STATUS, 32'h0000_00FF);
    st(5'b00000, 8'h3B, 3'b000);
  end endtask
  task t_gain; begin
    bus(1'b1, `LSMG_IDX_RXGAIN, 32'h0000_0040);
    rxSample <= 16'h1000;
    txSample <= 16'h2000;
    repeat (3) @(posedge clk);
    cmp({16'h0000, monitorOutput}, 32'h0000_1000);
    bus(1'b1, `LSMG_IDX_RXGAIN, 32'h0000_0000);
    bus(1'b1, `LSMG_IDX_TXGAIN, 32'h0000_0010);
    repeat (3) @(posedge clk);
    cmp({16'h0000, monitorOutput}, 32'h0000_0800);
    rd(`LSMG_IDX_TXGAIN, 32'h0000_0010);
  end endtask
  task t_irq; begin
    st(5'b10000, 8'h00, 3'b100);
    cmp({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b1, `LSMG_IDX_IRQMSK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    cmp({31'h0000_0000, irq}, 32'h0000_0001);
    rd(`LSMG_IDX_STICKY, 32'h0000_0001);
    rxInputExcessive <= 1'b0;
    bus(1'b1, `LSMG_IDX_IRQST, 32'h0000_0004);
    bus(1'b1, `LSMG_IDX_STICKY, 32'h0000_0000);
    rd(`LSMG_IDX_STICKY, 32'h0000_0000);
    cmp({31'h0000_0000, irq}, 32'h0000_0000);
  end endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`LSMG_IDX_RXGAIN, 32'h0000_0000);
    t_status;
    t_gain;
    t_irq;
    tally_and_finish;
  end
endmodule
